// ===== hdl/fpf_pkg.sv
// Constants, register map and word carriers of the HIPPI framing block
// What this block does
// (R01) Header bits 63:32 carry D2 size
// (R02) Header bits 31:24 carry bound ULP identifier
// (R03) Bits 21:11, D1 size, D2 offset default zero
// (R04) Descriptor I-field sent per connection, rewritable anytime
// (R05) I-field passed unaltered both directions
// (R06) Nonzero D1 size sets P, D1 leads payload
// (R07) First-burst size sets B, burst holds header/D1
// (R08) Under 256 words short burst, else standard
// (R09) First burst: 8-byte header, D1 up to 1016
// (R10) Single write: D2 = length minus D1 size
// (R11) Multiple write: D2 = byte count at start
// (R12) Header plus D1 first unit, D2 follows
// (R13) Route by ULP id, drop unmatched packets
// (R14) Framing mode frames every transmit and receive
// (R15) Each channel raw or framing, independently chosen
// (R16) Host buffers 8-byte aligned, multiples of 8
// (R17) Accept all packets, stall when buffers full
// (R18) Eight receive protocol bindings at once
`default_nettype none
package fpf_pkg;
  localparam logic [7:0]  FPF_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  FPF_IFIELD_OFS = 8'h04;
  localparam logic [7:0]  FPF_D1SIZE_OFS = 8'h08;
  localparam logic [7:0]  FPF_BURST_OFS  = 8'h0c;
  localparam logic [7:0]  FPF_ULPID_OFS  = 8'h10;
  localparam logic [7:0]  FPF_PKTCNT_OFS = 8'h14;
  localparam logic [7:0]  FPF_TXLEN_OFS  = 8'h18;
  localparam logic [7:0]  FPF_GO_OFS     = 8'h1c;
  localparam logic [7:0]  FPF_STATUS_OFS = 8'h20;
  localparam logic [7:0]  FPF_RXIFLD_OFS = 8'h24;
  localparam logic [7:0]  FPF_DROPS_OFS  = 8'h28;
  localparam logic [7:0]  FPF_BIND_OFS   = 8'h40;
  localparam logic [31:0] FPF_CTRL_RST   = 32'h0000_000c;
  localparam int FPF_TXEN_BIT  = 0;
  localparam int FPF_RXEN_BIT  = 1;
  localparam int FPF_TXFP_BIT  = 2;
  localparam int FPF_RXFP_BIT  = 3;
  localparam int FPF_MULTI_BIT = 4;
  localparam int FPF_NUM_ULP   = 8;
  localparam logic [8:0] FPF_STD_BURST = 9'h100;
  localparam int FPF_ULP_MSB   = 31;
  localparam int FPF_ULP_LSB   = 24;
  localparam int FPF_P_BIT     = 23;
  localparam int FPF_B_BIT     = 22;
  localparam int FPF_RSV_MSB   = 21;
  localparam int FPF_RSV_LSB   = 11;
  localparam int FPF_D1SZ_MSB  = 10;
  localparam int FPF_D1SZ_LSB  = 3;
  localparam int FPF_D1W_MSB   = 9;
  localparam int FPF_D1W_LSB   = 3;
  localparam int FPF_VALID_BIT = 8;
  localparam int FPF_BUF_DEPTH = 2;

  typedef struct packed {
    logic [63:0] data;
    logic        sop;
    logic        eop;
  } fpf_word_s;

  typedef struct packed {
    logic [63:0] data;
    logic        sop;
    logic        eop;
    logic        ifld;
    logic        burstEnd;
    logic        shortBurst;
  } fpf_txw_s;

  typedef struct packed {
    logic [63:0] data;
    logic        sop;
    logic        eop;
    logic        d2;
    logic        unitEnd;
    logic [2:0]  slot;
  } fpf_rxw_s;

  typedef logic [FPF_NUM_ULP-1:0][8:0] fpf_bind_t;
endpackage
`default_nettype wire

// ===== hdl/fpf_pair_buf.sv
// Small FIFO with valid and ready on both sides
`default_nettype none
module fpf_pair_buf #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  // Flags are registered from the next count so both stay honest
  assign push       = inValid && inReady;
  assign pop        = outValid && outReady;
  assign count_next = CW'(count_reg + CW'(push) - CW'(pop));
  assign outData    = mem[rdPtr_reg];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady   <= 1'b1;
      outValid  <= 1'b0;
    end else begin
      count_reg <= count_next;
      inReady   <= (count_next != CW'(DEPTH));
      outValid  <= (count_next != '0);
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : AW'(wrPtr_reg + 1'b1);
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : AW'(rdPtr_reg + 1'b1);
      end
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/fpf_ulp_match.sv
// Compare a received ULP identifier against the binding table
`default_nettype none
module fpf_ulp_match
  import fpf_pkg::*;
(
  input  wire fpf_bind_t  bindTable,
  input  wire logic [7:0] ulpId,
  output logic            hit,
  output logic [2:0]      slot
);
  logic [FPF_NUM_ULP-1:0] eq;

  // One comparator per binding slot, only live slots count
  for (genvar i = 0; i < FPF_NUM_ULP; i++) begin : g_cmp
    assign eq[i] = bindTable[i][FPF_VALID_BIT] && (bindTable[i][7:0] == ulpId);
  end

  // Lowest matching slot wins when two bindings share an id
  always_comb begin
    hit  = 1'b0;
    slot = 3'h0;
    for (int i = FPF_NUM_ULP - 1; i >= 0; i--) begin
      if (eq[i]) begin
        hit  = 1'b1;
        slot = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/fpf_framer_top.sv
// HIPPI framing layer: header build on transmit, split and demux on receive
//
// Added by the designer: the Avalon-MM register port and the address map.
`default_nettype none
module fpf_framer_top
  import fpf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  input  wire logic        hostTxValid,
  input  wire fpf_word_s   hostTxWord,
  output wire logic        hostTxReady,
  output logic             linkTxValid,
  output fpf_txw_s         linkTxWord,
  input  wire logic        linkTxReady,
  input  wire logic        linkRxValid,
  input  wire fpf_word_s   linkRxWord,
  output wire logic        linkRxReady,
  input  wire logic [31:0] linkRxIfield,
  input  wire logic        linkRxIfieldValid,
  output logic             hostRxValid,
  output fpf_rxw_s         hostRxWord,
  input  wire logic        hostRxReady
);
  typedef enum logic [2:0] {
    TX_IDLE, TX_IFLD, TX_HDR, TX_D1, TX_PAD, TX_DATA
  } fpf_tx_e;
  typedef enum logic [1:0] {RX_HDR, RX_D1, RX_D2, RX_DROP} fpf_rx_e;

  // Software-visible registers
  logic [31:0] ctrl_reg;
  logic [31:0] ifield_reg;
  logic [31:0] d1Size_reg;
  logic [8:0]  burst_reg;
  logic [7:0]  ulpId_reg;
  logic [31:0] pktCount_reg;
  logic [31:0] txLen_reg;
  fpf_bind_t   bind_reg;
  logic [31:0] rxIfield_reg;
  logic [15:0] drops_reg;
  logic [31:0] rdValue;
  logic        busReq;
  logic        wrEn;
  logic        goWrite;

  // Transmit state
  fpf_tx_e     txState_reg;
  logic        goPend_reg;
  logic [63:0] hdr_reg;
  logic        bFlag_reg;
  logic [8:0]  burstWords_reg;
  logic [8:0]  burstCnt_reg;
  logic [6:0]  d1Left_reg;
  logic [28:0] remW_reg;
  logic        sopPend_reg;
  logic        txStep;
  logic        bLast;
  logic        padMore;
  logic        txBufValid;
  logic        txBufReady;
  fpf_word_s   txBufWord;
  logic [6:0]  d1w;
  logic [31:0] d2Size;

  // Receive state
  fpf_rx_e     rxState_reg;
  logic [6:0]  rxD1Left_reg;
  logic [2:0]  rxSlot_reg;
  logic        rxStep;
  logic        rxTake;
  logic        rxBufValid;
  logic        rxBufReady;
  fpf_word_s   rxBufWord;
  logic        ulpHit;
  logic [2:0]  ulpSlot;
  logic [7:0]  rxD1f;

  function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic isBind(input logic [7:0] a);
    return (a[7:5] == FPF_BIND_OFS[7:5]) && (a[1:0] == 2'h0);
  endfunction

  function automatic fpf_txw_s mkTx(input logic [63:0] d, input logic s,
                                    input logic e, input logic i,
                                    input logic be, input logic sb);
    fpf_txw_s w;
    w.data       = d;
    w.sop        = s;
    w.eop        = e;
    w.ifld       = i;
    w.burstEnd   = be;
    w.shortBurst = sb;
    return w;
  endfunction

  function automatic fpf_rxw_s mkRx(input logic [63:0] d, input logic s,
                                    input logic e, input logic d2,
                                    input logic ue, input logic [2:0] sl);
    fpf_rxw_s w;
    w.data    = d;
    w.sop     = s;
    w.eop     = e;
    w.d2      = d2;
    w.unitEnd = ue;
    w.slot    = sl;
    return w;
  endfunction

  // Bus answer: one wait cycle, then a single ready cycle
  assign busReq  = (avsRead || avsWrite) && avsWaitrequest;
  assign wrEn    = avsWrite && !avsWaitrequest;
  assign goWrite = wrEn && (avsAddress == FPF_GO_OFS) && avsByteenable[0]
                   && avsWritedata[0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0;
    end else begin
      avsWaitrequest <= !busReq;
      if (busReq && avsRead) begin
        avsReaddata <= rdValue;
      end
    end
  end

  // Register writes; the I-field may be rewritten at any moment
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg     <= FPF_CTRL_RST;
      ifield_reg   <= 32'h0;
      d1Size_reg   <= 32'h0;
      burst_reg    <= 9'h0;
      ulpId_reg    <= 8'h0;
      pktCount_reg <= 32'h0;
      txLen_reg    <= 32'h0;
      bind_reg     <= '0;
    end else if (wrEn) begin
      case (avsAddress)
        FPF_CTRL_OFS:   ctrl_reg <= mergeBe(ctrl_reg, avsWritedata,
                                            avsByteenable);
        FPF_IFIELD_OFS: ifield_reg <= mergeBe(ifield_reg, avsWritedata,
                                              avsByteenable); // R04
        FPF_D1SIZE_OFS: d1Size_reg <= mergeBe(d1Size_reg, avsWritedata,
                                              avsByteenable);
        FPF_BURST_OFS:  burst_reg <= 9'(mergeBe({23'h0, burst_reg},
                                  avsWritedata, avsByteenable));
        FPF_ULPID_OFS:  ulpId_reg <= 8'(mergeBe({24'h0, ulpId_reg},
                                  avsWritedata, avsByteenable));
        FPF_PKTCNT_OFS: pktCount_reg <= mergeBe(pktCount_reg,
                                  avsWritedata, avsByteenable);
        FPF_TXLEN_OFS:  txLen_reg <= mergeBe(txLen_reg, avsWritedata,
                                             avsByteenable);
        default: ;
      endcase
      if (isBind(avsAddress)) begin
        bind_reg[avsAddress[4:2]] <= 9'(mergeBe({23'h0,
          bind_reg[avsAddress[4:2]]}, avsWritedata, avsByteenable)); // R18
      end
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rdValue = 32'h0;
    case (avsAddress)
      FPF_CTRL_OFS:   rdValue = ctrl_reg;
      FPF_IFIELD_OFS: rdValue = ifield_reg;
      FPF_D1SIZE_OFS: rdValue = d1Size_reg;
      FPF_BURST_OFS:  rdValue = {23'h0, burst_reg};
      FPF_ULPID_OFS:  rdValue = {24'h0, ulpId_reg};
      FPF_PKTCNT_OFS: rdValue = pktCount_reg;
      FPF_TXLEN_OFS:  rdValue = txLen_reg;
      FPF_STATUS_OFS: rdValue = {24'h0, 1'b0, rxState_reg, goPend_reg,
                                 txState_reg, (txState_reg != TX_IDLE)};
      FPF_RXIFLD_OFS: rdValue = rxIfield_reg;
      FPF_DROPS_OFS:  rdValue = {16'h0, drops_reg};
      default: begin
        if (isBind(avsAddress)) begin
          rdValue = {23'h0, bind_reg[avsAddress[4:2]]};
        end
      end
    endcase
  end

  // Transmit side buffer absorbs host words while the link stalls
  fpf_pair_buf #(
    .WIDTH ($bits(fpf_word_s)),
    .DEPTH (FPF_BUF_DEPTH)
  ) u_txBuf (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inValid  (hostTxValid),
    .inData   (hostTxWord),
    .inReady  (hostTxReady),
    .outValid (txBufValid),
    .outData  (txBufWord),
    .outReady (txBufReady)
  );

  // Packet geometry taken from the configuration at packet start
  assign d1w     = ctrl_reg[FPF_TXFP_BIT] ?
                   d1Size_reg[FPF_D1W_MSB:FPF_D1W_LSB] : 7'h0; // R09
  assign d2Size  = ctrl_reg[FPF_MULTI_BIT] ? pktCount_reg // R11
                   : 32'(txLen_reg - {22'h0, d1w, 3'h0}); // R10
  assign txStep  = !linkTxValid || linkTxReady;
  assign bLast   = bFlag_reg && (9'(burstCnt_reg + 1'b1) == burstWords_reg);
  assign padMore = bFlag_reg && (9'(burstCnt_reg + 1'b1) < burstWords_reg);
  assign txBufReady = txStep && ((txState_reg == TX_D1)
                                 || (txState_reg == TX_DATA));

  // Transmit framer; the output word register is the link's port
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txState_reg    <= TX_IDLE;
      goPend_reg     <= 1'b0;
      hdr_reg        <= 64'h0;
      bFlag_reg      <= 1'b0;
      burstWords_reg <= 9'h0;
      burstCnt_reg   <= 9'h0;
      d1Left_reg     <= 7'h0;
      remW_reg       <= 29'h0;
      sopPend_reg    <= 1'b0;
      linkTxValid    <= 1'b0;
      linkTxWord     <= '0;
    end else begin
      if (goWrite) begin
        goPend_reg <= 1'b1;
      end else if (txState_reg == TX_IDLE && txStep) begin
        goPend_reg <= 1'b0;
      end
      if (txStep) begin
        linkTxValid <= 1'b0;
        case (txState_reg)
          TX_IDLE: begin
            if (goPend_reg && ctrl_reg[FPF_TXEN_BIT]) begin
              hdr_reg <= {d2Size, ulpId_reg, (d1w != 7'h0), // R01 R02 R06
                          ctrl_reg[FPF_TXFP_BIT] && (burst_reg != 9'h0),
                          11'h0, 1'b0, d1w, 3'h0}; // R03 R07
              bFlag_reg      <= ctrl_reg[FPF_TXFP_BIT] && (burst_reg != 9'h0);
              burstWords_reg <= burst_reg;
              burstCnt_reg   <= 9'h0;
              d1Left_reg     <= d1w;
              remW_reg       <= ctrl_reg[FPF_MULTI_BIT] ?
                                29'(pktCount_reg[31:3] + {22'h0, d1w})
                                : txLen_reg[31:3]; // R16
              txState_reg    <= TX_IFLD;
            end
          end
          TX_IFLD: begin
            linkTxValid <= 1'b1;
            linkTxWord  <= mkTx({32'h0, ifield_reg}, 1'b0, 1'b0, 1'b1,
                                1'b0, 1'b0); // R04 R05
            sopPend_reg <= 1'b1;
            if (ctrl_reg[FPF_TXFP_BIT]) begin
              txState_reg <= TX_HDR; // R14
            end else begin
              txState_reg <= (remW_reg != 29'h0) ? TX_DATA : TX_IDLE; // R15
            end
          end
          TX_HDR: begin
            linkTxValid  <= 1'b1;
            linkTxWord   <= mkTx(hdr_reg, 1'b1,
                                 (remW_reg == 29'h0) && !padMore, 1'b0,
                                 bLast, burstWords_reg < FPF_STD_BURST); // R08
            sopPend_reg  <= 1'b0;
            burstCnt_reg <= 9'(burstCnt_reg + 1'b1);
            if (d1Left_reg != 7'h0) begin
              txState_reg <= TX_D1;
            end else if (padMore) begin
              txState_reg <= TX_PAD;
            end else begin
              txState_reg <= (remW_reg != 29'h0) ? TX_DATA : TX_IDLE;
            end
          end
          TX_D1: begin
            if (txBufValid) begin
              linkTxValid  <= 1'b1;
              linkTxWord   <= mkTx(txBufWord.data, 1'b0,
                                   (remW_reg == 29'h1) && !padMore, 1'b0,
                                   bLast, burstWords_reg < FPF_STD_BURST);
              d1Left_reg   <= 7'(d1Left_reg - 1'b1); // R06
              remW_reg     <= 29'(remW_reg - 1'b1);
              burstCnt_reg <= 9'(burstCnt_reg + 1'b1);
              if (d1Left_reg != 7'h1) begin
                txState_reg <= TX_D1;
              end else if (padMore) begin
                txState_reg <= TX_PAD; // R07
              end else begin
                txState_reg <= (remW_reg != 29'h1) ? TX_DATA : TX_IDLE;
              end
            end
          end
          TX_PAD: begin
            // Filler keeps D2 out of the first burst
            linkTxValid  <= 1'b1;
            linkTxWord   <= mkTx(64'h0, 1'b0,
                                 !padMore && (remW_reg == 29'h0), 1'b0,
                                 bLast, burstWords_reg < FPF_STD_BURST); // R07
            burstCnt_reg <= 9'(burstCnt_reg + 1'b1);
            if (!padMore) begin
              txState_reg <= (remW_reg != 29'h0) ? TX_DATA : TX_IDLE;
            end
          end
          TX_DATA: begin
            if (txBufValid) begin
              linkTxValid <= 1'b1;
              linkTxWord  <= mkTx(txBufWord.data, sopPend_reg,
                                  remW_reg == 29'h1, 1'b0, 1'b0, 1'b0);
              sopPend_reg <= 1'b0;
              remW_reg    <= 29'(remW_reg - 1'b1);
              if (remW_reg == 29'h1) begin
                txState_reg <= TX_IDLE;
              end
            end
          end
          default: txState_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer; its ready is the stall seen by the link
  fpf_pair_buf #(
    .WIDTH ($bits(fpf_word_s)),
    .DEPTH (FPF_BUF_DEPTH)
  ) u_rxBuf (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .inValid  (linkRxValid),
    .inData   (linkRxWord),
    .inReady  (linkRxReady), // R17
    .outValid (rxBufValid),
    .outData  (rxBufWord),
    .outReady (rxBufReady)
  );

  fpf_ulp_match u_match (
    .bindTable (bind_reg),
    .ulpId     (rxBufWord.data[FPF_ULP_MSB:FPF_ULP_LSB]),
    .hit       (ulpHit),
    .slot      (ulpSlot)
  );

  // Dropped packets drain at full rate, others wait on the host
  assign rxStep     = !hostRxValid || hostRxReady;
  assign rxBufReady = ctrl_reg[FPF_RXEN_BIT]
                      && ((rxState_reg == RX_DROP) || rxStep); // R17
  assign rxTake     = rxBufValid && rxBufReady;
  assign rxD1f      = rxBufWord.data[FPF_D1SZ_MSB:FPF_D1SZ_LSB];

  // Received I-field is kept as it came, never decoded
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxIfield_reg <= 32'h0;
    end else if (linkRxIfieldValid) begin
      rxIfield_reg <= linkRxIfield; // R05
    end
  end

  // Receive splitter and demultiplexer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_reg  <= RX_HDR;
      rxD1Left_reg <= 7'h0;
      rxSlot_reg   <= 3'h0;
      drops_reg    <= 16'h0;
      hostRxValid  <= 1'b0;
      hostRxWord   <= '0;
    end else begin
      if (rxStep) begin
        hostRxValid <= 1'b0;
      end
      if (rxTake) begin
        case (rxState_reg)
          RX_HDR: begin
            if (!ctrl_reg[FPF_RXFP_BIT]) begin
              hostRxValid <= 1'b1; // R15
              hostRxWord  <= mkRx(rxBufWord.data, rxBufWord.sop,
                                  rxBufWord.eop, 1'b1, 1'b0, 3'h0);
              rxState_reg <= rxBufWord.eop ? RX_HDR : RX_D2;
            end else if (ulpHit && rxBufWord.sop && (rxD1f[7] == 1'b0)
                && (rxBufWord.data[FPF_RSV_MSB:FPF_RSV_LSB] == 11'h0)) begin
              hostRxValid  <= 1'b1; // R12 R14
              hostRxWord   <= mkRx(rxBufWord.data, 1'b1, rxBufWord.eop,
                                   1'b0, rxD1f == 8'h0, ulpSlot);
              rxSlot_reg   <= ulpSlot; // R13
              rxD1Left_reg <= rxD1f[6:0];
              if (rxBufWord.eop) begin
                rxState_reg <= RX_HDR;
              end else begin
                rxState_reg <= (rxD1f != 8'h0) ? RX_D1 : RX_D2;
              end
            end else begin
              // Unknown id or bad header: whole packet is discarded
              drops_reg   <= 16'(drops_reg + 1'b1); // R13
              rxState_reg <= rxBufWord.eop ? RX_HDR : RX_DROP;
            end
          end
          RX_D1: begin
            hostRxValid  <= 1'b1;
            hostRxWord   <= mkRx(rxBufWord.data, 1'b0, rxBufWord.eop, 1'b0,
                                 rxD1Left_reg == 7'h1, rxSlot_reg); // R12
            rxD1Left_reg <= 7'(rxD1Left_reg - 1'b1);
            if (rxBufWord.eop) begin
              rxState_reg <= RX_HDR;
            end else if (rxD1Left_reg == 7'h1) begin
              rxState_reg <= RX_D2;
            end
          end
          RX_D2: begin
            hostRxValid <= 1'b1;
            hostRxWord  <= mkRx(rxBufWord.data, 1'b0, rxBufWord.eop, 1'b1,
                                1'b0, rxSlot_reg);
            if (rxBufWord.eop) begin
              rxState_reg <= RX_HDR;
            end
          end
          RX_DROP: begin
            if (rxBufWord.eop) begin
              rxState_reg <= RX_HDR;
            end
          end
          default: rxState_reg <= RX_HDR;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/fpf_framer_checker.sv
// Checker: bus wait timing, stream holding, received header fields
`default_nettype none
module fpf_framer_checker import fpf_pkg::*; (
  input wire logic     core_clk, rst_b, avsRead, avsWrite, avsWaitrequest,
  input wire logic     linkTxValid, linkTxReady, hostRxValid, hostRxReady,
  input wire fpf_txw_s linkTxWord,
  input wire fpf_rxw_s hostRxWord
);
  timeunit 1ns / 1ns;
  // One clock domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic hdr = hostRxValid && hostRxWord.sop;
  wait_one_a: assert property ((avsRead || avsWrite) && avsWaitrequest
    |=> !avsWaitrequest) else $error("bus answer late");
  ack_pulse_a: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("bus ack too long");
  tx_hold_a: assert property (linkTxValid && !linkTxReady
    |=> linkTxValid && $stable(linkTxWord)) else $error("tx word moved");
  rx_hold_a: assert property (hostRxValid && !hostRxReady
    |=> hostRxValid && $stable(hostRxWord)) else $error("rx word lost");
  ifld_alone_a: assert property (linkTxValid && linkTxWord.ifld
    |-> !linkTxWord.sop && !linkTxWord.eop) else $error("ifield framed");
  head_unit_a: assert property (hdr |-> !hostRxWord.d2)
    else $error("header flagged d2");
  head_rsv_a: assert property (hdr |-> !(|hostRxWord.data[21:11]))
    else $error("bad header passed");
  // D1 above 127 words would exceed 1016 bytes
  head_d1_a: assert property (hdr |-> !hostRxWord.data[10])
    else $error("oversized D1 passed");
endmodule
`default_nettype wire

// ===== verification/fpf_link_model.sv
// Far-end link partner: sinks framed words with stalls, sends packets
`default_nettype none
module fpf_link_model import fpf_pkg::*; (
  input  wire logic   core_clk,
  input  wire logic   linkTxValid,
  input  wire fpf_txw_s linkTxWord,
  output logic        linkTxReady,
  output logic        linkRxValid,
  output fpf_word_s   linkRxWord,
  input  wire logic   linkRxReady,
  output logic [31:0] linkRxIfield,
  output logic        linkRxIfieldValid
);
  timeunit 1ns / 1ns;
  fpf_txw_s   got[$];
  logic [1:0] cnt = 2'h0;
  initial {linkTxReady, linkRxValid, linkRxWord, linkRxIfield,
    linkRxIfieldValid} = '0;
  // Ready drops two cycles in four, as a busy switch port would
  always @(posedge core_clk) begin
    cnt <= cnt + 2'h1;
    linkTxReady <= cnt[1];
    if (linkTxValid && linkTxReady) got.push_back(linkTxWord);
  end
  // Connection: I-field pulse, then header and numbered data words
  task automatic pkt(logic [31:0] f, logic [63:0] h, int n);
    linkRxIfield <= f;
    linkRxIfieldValid <= 1'b1;
    @(posedge core_clk);
    linkRxIfieldValid <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      linkRxValid <= 1'b1;
      linkRxWord <= '{i == 0 ? h : 64'(i), i == 0, i == n};
      do @(posedge core_clk); while (linkRxReady !== 1'b1);
    end
    linkRxValid <= 1'b0;
    linkRxWord.data <= ~linkRxWord.data; // Released bus keeps no word
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_fpf_framer_top.sv
// Bench: register access, framed transmit and filtered receive
`default_nettype none
module tb_fpf_framer_top import fpf_pkg::*; ;
  timeunit 1ns / 1ns;
  logic core_clk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic [7:0] avsAddress = 8'h00;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, linkRxIfield, rdat;
  logic avsWaitrequest, hostTxValid = 1'b0, hostTxReady, linkTxValid;
  logic linkTxReady, linkRxValid, linkRxReady, linkRxIfieldValid;
  logic hostRxValid, hostRxReady = 1'b0;
  fpf_word_s hostTxWord = '0, linkRxWord;
  fpf_txw_s linkTxWord, t[$];
  fpf_rxw_s hostRxWord, rxq[$];
  int badCount = 0, samplesChecked = 0, cyc = 0;
  logic [7:0] cfgA [9] = '{FPF_BIND_OFS, 8'h5c, FPF_ULPID_OFS,
    FPF_IFIELD_OFS, FPF_D1SIZE_OFS, FPF_BURST_OFS, FPF_TXLEN_OFS,
    FPF_CTRL_OFS, FPF_GO_OFS};
  logic [31:0] cfgD [9] = '{32'h15a, 32'h133, 32'h5a, 32'h1234_abcd,
    32'h8, 32'h4, 32'h18, 32'hf, 32'h1};
  always #5 core_clk = ~core_clk;
  fpf_framer_top u_dut (.core_clk, .rst_b, .avsAddress, .avsRead,
    .avsWrite, .avsWritedata, .avsByteenable(4'hf), .avsReaddata,
    .avsWaitrequest, .hostTxValid, .hostTxWord, .hostTxReady, .linkTxValid,
    .linkTxWord, .linkTxReady, .linkRxValid, .linkRxWord, .linkRxReady,
    .linkRxIfield, .linkRxIfieldValid, .hostRxValid, .hostRxWord,
    .hostRxReady);
  fpf_link_model u_link (.core_clk, .linkTxValid, .linkTxWord, .linkTxReady,
    .linkRxValid, .linkRxWord, .linkRxReady, .linkRxIfield,
    .linkRxIfieldValid);
  task automatic chk(logic [63:0] g, e);
    samplesChecked++;
    if (g !== e) begin
      badCount++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One bus cycle; an idle edge after it keeps drivers from colliding
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
    rdat = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic hput(int n);
    for (int i = 0; i < n; i++) begin
      hostTxValid <= 1'b1;
      hostTxWord.data <= 64'h100 + 64'(i);
      do @(posedge core_clk); while (hostTxReady !== 1'b1);
    end
    hostTxValid <= 1'b0;
  endtask
  task automatic conclude();
    if (badCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Host read side stalls in bursts; the cycle count also cuts hangs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    hostRxReady <= cyc[2];
    if (hostRxValid && hostRxReady) rxq.push_back(hostRxWord);
    if (cyc == 20000) begin
      badCount++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    bus(0, FPF_CTRL_OFS, 0);
    chk(rdat, FPF_CTRL_RST);
    bus(0, 8'h3c, 0);
    chk(rdat, 0);
    foreach (cfgA[i]) bus(1, cfgA[i], cfgD[i]);
    hput(3);
    while (u_link.got.size() < 7) @(posedge core_clk);
    t = u_link.got;
    chk(t[1].data, 64'h0000_0010_5ac0_0008);
    chk({t[0].data[31:0], t[2].data[31:0]}, 64'h1234_abcd_0000_0100);
    chk(t[3].data | t[4].data, 64'h0);
    chk({t[4].burstEnd, t[4].shortBurst}, 2'h3);
    chk({t[6].eop, t[6].data[7:0]}, 9'h102);
    u_link.pkt(32'hcafe_0001, 64'h0000_0010_3300_0000, 2);
    bus(0, FPF_RXIFLD_OFS, 0);
    chk(rdat, 32'hcafe_0001);
    u_link.pkt(32'h0, 64'h0000_0008_7700_0000, 1);
    do bus(0, FPF_DROPS_OFS, 0); while (rdat == 0);
    while (rxq.size() < 3) @(posedge core_clk);
    chk(rdat, 1);
    chk({rxq[0].sop, rxq[0].d2, rxq[0].unitEnd, rxq[0].slot}, 6'h2f);
    chk(rxq[0].data, 64'h0000_0010_3300_0000);
    chk({rxq[1].d2, rxq[2].d2, rxq[2].eop, rxq[2].data[7:0]}, 11'h702);
    conclude();
  end
endmodule
bind fpf_framer_top fpf_framer_checker u_chk (.core_clk, .rst_b, .avsRead,
  .avsWrite, .avsWaitrequest, .linkTxValid, .linkTxReady, .hostRxValid,
  .hostRxReady, .linkTxWord, .hostRxWord);
`default_nettype wire
